// ==== hw/rbp_pkg.sv ====
package rbp_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Port widths
   localparam int DATA_W = 8;
   localparam int PIN_W = 23;
   localparam int ADDR_W = 12;

   // Every pin that enters the core clock domain, synchronised as one group
   typedef struct packed {
      logic [7:0] aData;
      logic [7:0] bData;
      logic parity;
      logic aToBLoadClock;
      logic bToALoadClock;
      logic aToBLoadEnableN;
      logic bToALoadEnableN;
      logic aPortDriveEnableN;
      logic bPortDriveEnableN;
   } rbp_pin_s;

   // Clocks and active-low enables idle high so release makes no false edge
   localparam logic [22:0] PIN_RESET = 23'h00003f;

   ////////////////////////////////////////////////////////////////////////////
   // Register offsets (byte addresses)
   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] STATUS_OFS = 12'h004;
   localparam logic [11:0] IRQ_EN_OFS = 12'h008;
   localparam logic [11:0] IRQ_CLR_OFS = 12'h00c;
   localparam logic [11:0] PORT_STATE_OFS = 12'h010;

   // Control fields
   localparam int CTRL_W = 2;
   localparam int CTRL_A2B_HOLD = 0;
   localparam int CTRL_B2A_HOLD = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;

   // Event bits, shared by status, enable and clear registers
   localparam int EV_W = 5;
   localparam int EV_A2B_LOAD = 0;
   localparam int EV_B2A_LOAD = 1;
   localparam int EV_A2B_ACK = 2;
   localparam int EV_B2A_ACK = 3;
   localparam int EV_PARITY = 4;
   localparam logic [4:0] EV_RESET = 5'h00;

   // Port state fields
   localparam int PS_A2B_LSB = 0;
   localparam int PS_B2A_LSB = 8;
   localparam int PS_PARITY = 16;
   localparam int PS_A2B_FULL = 17;
   localparam int PS_B2A_FULL = 18;
   localparam int PS_FAULT_N = 19;

   // Values after reset
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [31:0] WORD_RESET = 32'h00000000;

endpackage

// ==== hw/rbp_sync.sv ====
`timescale 1ns/100ps

module rbp_sync #(
   parameter int WIDTH = 23,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // Asynchronous in, synchronised out
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);

   logic [WIDTH-1:0] stage1_reg;
   logic [WIDTH-1:0] stage2_reg;

   generate
      if (WIDTH < 1)
      begin : g_bad_width
         $error("rbp_sync width must be at least one");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Two stages; only the second stage reads the first
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         stage1_reg <= RESET_VAL;
         stage2_reg <= RESET_VAL;
      end
      else
      begin
         stage1_reg <= asyncIn;
         stage2_reg <= stage1_reg;
      end
   end

   assign syncOut = stage2_reg;

endmodule // rbp_sync

// ==== hw/rbp_lane.sv ====
`timescale 1ns/100ps

module rbp_lane #(
   parameter int WIDTH = 8
)
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // Load side
   input wire logic loadStb,
   input wire logic [WIDTH-1:0] loadData,
   // Drain side
   input wire logic clearStb,
   output logic [WIDTH-1:0] holdData,
   output logic fullFlag
);

   logic [WIDTH-1:0] hold_reg;
   logic [WIDTH-1:0] hold_next;
   logic full_reg;
   logic full_next;

   generate
      if (WIDTH < 1)
      begin : g_bad_width
         $error("rbp_lane width must be at least one");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Holding register and its flag; the acknowledge beats a same-cycle load
   always_comb
   begin
      hold_next = hold_reg;
      full_next = full_reg;
      if (loadStb)
      begin
         hold_next = loadData;
         full_next = 1'b1;
      end
      if (clearStb)
      begin
         full_next = 1'b0;
      end
   end

   // Flags start empty so the handshake has a known origin
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         hold_reg <= '0;
         full_reg <= 1'b0;
      end
      else
      begin
         hold_reg <= hold_next;
         full_reg <= full_next;
      end
   end

   assign holdData = hold_reg;
   assign fullFlag = full_reg;

endmodule // rbp_lane

// ==== hw/rbp_port.sv ====
`timescale 1ns/100ps
// Functional notes
// - Qualified A-to-B load edge captures the A-side byte into its holder.
// - That load edge sets the A-to-B full flag unless acknowledge coincides.
// - Without a qualified edge, holding register keeps contents; full flag too unless acknowledged.
// - B pins show the A-to-B holder only while B drive enable is low.
// - Driven parity pin is high for even ones count, low for odd.
// - Rising B drive enable clears the A-to-B full flag unconditionally.
// - Qualified B-to-A edge stores B byte, parity pin, sets its flag.
// - A pins show the B-to-A holder only while A drive enable is low.
// - Rising A drive enable clears the B-to-A flag, beating any load.
// - Fault output low on even ones in byte plus parity, when enabled.
// - Parity pin is input for B-to-A, driven output for A-to-B.

module rbp_port
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // A-side pins
   input wire logic [7:0] aPortIn,
   output logic [7:0] aPortOut,
   output logic aPortOe,
   // B-side pins and parity
   input wire logic [7:0] bPortIn,
   output logic [7:0] bPortOut,
   output logic bPortOe,
   input wire logic parityIn,
   output logic parityOut,
   output logic parityOe,
   // Transfer control pins
   input wire logic a_to_b_load_clock,
   input wire logic b_to_a_load_clock,
   input wire logic a_to_b_load_enable_n,
   input wire logic b_to_a_load_enable_n,
   input wire logic a_port_drive_enable_n,
   input wire logic b_port_drive_enable_n,
   // Status pins and interrupt
   output logic a_to_b_full_flag,
   output logic b_to_a_full_flag,
   output logic parity_fault_n,
   output logic irq
);

   rbp_pkg::rbp_pin_s pinRaw;
   rbp_pkg::rbp_pin_s pinSync;
   rbp_pkg::rbp_pin_s pinPrev_reg;
   logic aLoadStb;
   logic bLoadStb;
   logic bDriveRise;
   logic aDriveRise;
   logic [7:0] aToBData;
   logic [8:0] bToAWord;
   logic parOut_reg;
   logic parOut_next;
   logic faultN_reg;
   logic faultN_next;
   logic [1:0] ctrl_reg;
   logic [1:0] ctrl_next;
   logic [4:0] status_reg;
   logic [4:0] status_next;
   logic [4:0] irqEn_reg;
   logic [4:0] irqEn_next;
   logic irq_reg;
   logic irq_next;
   logic [4:0] events;
   logic ready_reg;
   logic ready_next;
   logic err_reg;
   logic err_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic wrTake;

   ////////////////////////////////////////////////////////////////////////////
   // Pin capture: every pin passes two flops before any logic sees it
   assign pinRaw = '{aData: aPortIn, bData: bPortIn, parity: parityIn,
      aToBLoadClock: a_to_b_load_clock, bToALoadClock: b_to_a_load_clock,
      aToBLoadEnableN: a_to_b_load_enable_n,
      bToALoadEnableN: b_to_a_load_enable_n,
      aPortDriveEnableN: a_port_drive_enable_n,
      bPortDriveEnableN: b_port_drive_enable_n};

   rbp_sync #(
      .WIDTH(rbp_pkg::PIN_W),
      .RESET_VAL(rbp_pkg::PIN_RESET)
   ) u_sync (
      .core_clk(core_clk),
      .srst(srst),
      .asyncIn(pinRaw),
      .syncOut(pinSync)
   );

   // One more stage for edge detection; data is taken from the same stage
   // as the clock, so pins must be steady for two core cycles around an edge
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         pinPrev_reg <= rbp_pkg::PIN_RESET;
      end
      else
      begin
         pinPrev_reg <= pinSync;
      end
   end

   // Qualified load edges; software may hold either direction off
   assign aLoadStb = pinSync.aToBLoadClock && !pinPrev_reg.aToBLoadClock
      && !pinSync.aToBLoadEnableN && !ctrl_reg[rbp_pkg::CTRL_A2B_HOLD];
   assign bLoadStb = pinSync.bToALoadClock && !pinPrev_reg.bToALoadClock
      && !pinSync.bToALoadEnableN && !ctrl_reg[rbp_pkg::CTRL_B2A_HOLD];
   // Acknowledge edges
   assign bDriveRise = pinSync.bPortDriveEnableN
      && !pinPrev_reg.bPortDriveEnableN;
   assign aDriveRise = pinSync.aPortDriveEnableN
      && !pinPrev_reg.aPortDriveEnableN;

   ////////////////////////////////////////////////////////////////////////////
   // The two holding lanes
   rbp_lane #(
      .WIDTH(rbp_pkg::DATA_W)
   ) u_a2b (
      .core_clk(core_clk),
      .srst(srst),
      .loadStb(aLoadStb),
      .loadData(pinSync.aData),
      .clearStb(bDriveRise),
      .holdData(aToBData),
      .fullFlag(a_to_b_full_flag)
   );

   // Parity pin sampled alongside the B byte
   rbp_lane #(
      .WIDTH(rbp_pkg::DATA_W + 1)
   ) u_b2a (
      .core_clk(core_clk),
      .srst(srst),
      .loadStb(bLoadStb),
      .loadData({pinSync.parity, pinSync.bData}),
      .clearStb(aDriveRise),
      .holdData(bToAWord),
      .fullFlag(b_to_a_full_flag)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Pin drivers; enables follow the synchronised drive enables
   assign bPortOut = aToBData;
   assign bPortOe = !pinSync.bPortDriveEnableN;
   assign parityOe = !pinSync.bPortDriveEnableN;
   assign aPortOut = bToAWord[7:0];
   assign aPortOe = !pinSync.aPortDriveEnableN;
   assign parityOut = parOut_reg;
   assign parity_fault_n = faultN_reg;

   // Parity generate and check, registered so the pins never glitch
   always_comb
   begin
      parOut_next = ~^aToBData;
      faultN_next = 1'b1;
      if (!pinSync.aPortDriveEnableN)
      begin
         faultN_next = ^bToAWord;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         parOut_reg <= 1'b1;
         faultN_reg <= 1'b1;
      end
      else
      begin
         parOut_reg <= parOut_next;
         faultN_reg <= faultN_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Events; a fault counts when the check output falls
   always_comb
   begin
      events = rbp_pkg::EV_RESET;
      events[rbp_pkg::EV_A2B_LOAD] = aLoadStb;
      events[rbp_pkg::EV_B2A_LOAD] = bLoadStb;
      events[rbp_pkg::EV_A2B_ACK] = bDriveRise;
      events[rbp_pkg::EV_B2A_ACK] = aDriveRise;
      events[rbp_pkg::EV_PARITY] = faultN_reg && !faultN_next;
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB slave: one wait state so read data comes from a flop
   assign wrTake = psel && penable && ready_reg && pwrite;

   always_comb
   begin
      ready_next = psel && penable && !ready_reg;
      err_next = 1'b0;
      rdata_next = rbp_pkg::WORD_RESET;
      ctrl_next = ctrl_reg;
      irqEn_next = irqEn_reg;
      status_next = status_reg | events;
      if (psel && penable && !ready_reg)
      begin
         if (paddr == rbp_pkg::CTRL_OFS)
         begin
            rdata_next[1:0] = ctrl_reg;
         end
         else if (paddr == rbp_pkg::STATUS_OFS)
         begin
            rdata_next[4:0] = status_reg;
         end
         else if (paddr == rbp_pkg::IRQ_EN_OFS)
         begin
            rdata_next[4:0] = irqEn_reg;
         end
         else if (paddr == rbp_pkg::IRQ_CLR_OFS)
         begin
            rdata_next = rbp_pkg::WORD_RESET;
         end
         else if (paddr == rbp_pkg::PORT_STATE_OFS)
         begin
            rdata_next[rbp_pkg::PS_A2B_LSB +: 8] = aToBData;
            rdata_next[rbp_pkg::PS_B2A_LSB +: 8] = bToAWord[7:0];
            rdata_next[rbp_pkg::PS_PARITY] = bToAWord[8];
            rdata_next[rbp_pkg::PS_A2B_FULL] = a_to_b_full_flag;
            rdata_next[rbp_pkg::PS_B2A_FULL] = b_to_a_full_flag;
            rdata_next[rbp_pkg::PS_FAULT_N] = faultN_reg;
         end
         else
         begin
            err_next = 1'b1;
         end
      end
      // Writes land on the edge that completes the access
      if (wrTake && pstrb[0])
      begin
         if (paddr == rbp_pkg::CTRL_OFS)
         begin
            ctrl_next = pwdata[1:0];
         end
         else if (paddr == rbp_pkg::IRQ_EN_OFS)
         begin
            irqEn_next = pwdata[4:0];
         end
         else if (paddr == rbp_pkg::IRQ_CLR_OFS)
         begin
            // A new event in the clearing cycle survives
            status_next = (status_reg & ~pwdata[4:0]) | events;
         end
      end
      irq_next = |(status_next & irqEn_next);
   end

   // Bus registers; control defaults let both directions load
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         ready_reg <= 1'b0;
         err_reg <= 1'b0;
         rdata_reg <= rbp_pkg::WORD_RESET;
         ctrl_reg <= rbp_pkg::CTRL_RESET;
         irqEn_reg <= rbp_pkg::EV_RESET;
         status_reg <= rbp_pkg::EV_RESET;
         irq_reg <= 1'b0;
      end
      else
      begin
         ready_reg <= ready_next;
         err_reg <= err_next;
         rdata_reg <= rdata_next;
         ctrl_reg <= ctrl_next;
         irqEn_reg <= irqEn_next;
         status_reg <= status_next;
         irq_reg <= irq_next;
      end
   end

   assign pready = ready_reg;
   assign pslverr = err_reg && ready_reg;
   assign prdata = rdata_reg;
   assign irq = irq_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (srst);

   a_a2b_capture: assert property (aLoadStb |=>
      aToBData == $past(pinSync.aData))
      else $error("A-to-B byte not captured");
   a_a2b_flag_set: assert property (aLoadStb && !bDriveRise |=>
      a_to_b_full_flag)
      else $error("A-to-B flag not set by load");
   a_lane_hold: assert property (!aLoadStb && !bDriveRise |=>
      $stable(aToBData) && $stable(a_to_b_full_flag))
      else $error("A-to-B lane changed without cause");
   a_b_drive: assert property (bPortOut == aToBData &&
      bPortOe == !$past(b_port_drive_enable_n, 2))
      else $error("B pins driven wrongly");
   a_parity_gen: assert property (parityOe |->
      parityOut == ~^$past(aToBData))
      else $error("Generated parity wrong");
   a_a2b_clear: assert property (bDriveRise |=>
      !a_to_b_full_flag)
      else $error("A-to-B flag not cleared");
   a_b2a_capture: assert property (bLoadStb |=>
      bToAWord == {$past(pinSync.parity), $past(pinSync.bData)}
      && b_to_a_full_flag == !$past(aDriveRise))
      else $error("B-to-A word not captured");
   a_a_drive: assert property (aPortOut == bToAWord[7:0] &&
      aPortOe == !$past(a_port_drive_enable_n, 2))
      else $error("A pins driven wrongly");
   a_b2a_clear: assert property (aDriveRise |=>
      !b_to_a_full_flag)
      else $error("B-to-A flag not cleared");
   a_fault_check: assert property (1'b1 |=> parity_fault_n ==
      ($past(pinSync.aPortDriveEnableN) || ^$past(bToAWord)))
      else $error("Fault output wrong");
   a_parity_dir: assert property (
      parityOe == !$past(b_port_drive_enable_n, 2))
      else $error("Parity pin driven while input");

endmodule // rbp_port

// ==== verif/rbp_far_model.sv ====
`timescale 1ns/100ps
////////////////////////////////////////////////////////////
// Sender and receiver on both ports, paced by the core clock
module rbp_far_model
(
   // Clock
   input wire logic core_clk,
   // Pins toward the device
   output logic [7:0] aDrv,
   output logic [7:0] bDrv,
   output logic parDrv,
   output logic aClk,
   output logic bClk,
   output logic aEnN,
   output logic bEnN,
   output logic aOeN,
   output logic bOeN
);
   // Idle: clocks low, active-low controls high
   initial
   begin
      {aDrv, bDrv, parDrv, aClk, bClk} = '0;
      {aEnN, bEnN, aOeN, bOeN} = 4'hf;
   end

   // Side 0 loads A-to-B. Data held 3 cycles each side of the edge,
   // since the device only sees pins through its synchronisers
   task automatic send(input bit side, input logic [7:0] d,
      input logic p, input logic enN, input bit ack);
      @(posedge core_clk);
      if (side)
      begin
         bDrv <= d;
         parDrv <= p;
         bEnN <= enN;
      end
      else
      begin
         aDrv <= d;
         aEnN <= enN;
      end
      repeat (3) @(posedge core_clk);
      aClk <= !side;
      bClk <= side;
      // Optional acknowledge of the same direction on the same edge
      if (ack && side)
         aOeN <= 1'b1;
      else if (ack)
         bOeN <= 1'b1;
      repeat (3) @(posedge core_clk);
      {aClk, bClk, aEnN, bEnN} <= 4'h3;
      // Released lines show the inverse, never a stale copy
      aDrv <= ~aDrv;
      bDrv <= ~bDrv;
      parDrv <= ~parDrv;
      repeat (3) @(posedge core_clk);
   endtask

   // Receiver's drive enable; side 0 is the B port reader
   task automatic drive(input bit side, input logic lvl);
      @(posedge core_clk);
      if (side)
         aOeN <= lvl;
      else
         bOeN <= lvl;
   endtask
endmodule // rbp_far_model

// ==== verif/registered_byte_port_parity_tb.sv ====
`timescale 1ns/100ps
////////////////////////////////////////////////////////////
module registered_byte_port_parity_tb;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [3:0] pstrb = 4'hf;
   logic pready, pslverr, err;
   logic [7:0] aPortIn, aPortOut, bPortIn, bPortOut, aDrv, bDrv;
   logic aPortOe, bPortOe, parityIn, parityOut, parityOe, parDrv;
   logic aClk, bClk, aEnN, bEnN, aOeN, bOeN;
   logic aFull, bFull, faultN, irq;
   logic [7:0] vals [5] = '{8'h00, 8'h01, 8'h03, 8'hff, 8'ha5};
   int badCount = 0, checksDone = 0;

   // Free-running core clock
   initial
   begin
      forever #5 core_clk = ~core_clk;
   end

   // Each shared line resolved from the device's output enable alone
   assign aPortIn = aPortOe ? aPortOut : aDrv;
   assign bPortIn = bPortOe ? bPortOut : bDrv;
   assign parityIn = parityOe ? parityOut : parDrv;

   rbp_port dut_u (.core_clk(core_clk), .srst(srst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .aPortIn(aPortIn),
      .aPortOut(aPortOut), .aPortOe(aPortOe), .bPortIn(bPortIn),
      .bPortOut(bPortOut), .bPortOe(bPortOe), .parityIn(parityIn),
      .parityOut(parityOut), .parityOe(parityOe),
      .a_to_b_load_clock(aClk), .b_to_a_load_clock(bClk),
      .a_to_b_load_enable_n(aEnN), .b_to_a_load_enable_n(bEnN),
      .a_port_drive_enable_n(aOeN), .b_port_drive_enable_n(bOeN),
      .a_to_b_full_flag(aFull), .b_to_a_full_flag(bFull),
      .parity_fault_n(faultN), .irq(irq));

   rbp_far_model model_u (.core_clk(core_clk), .aDrv(aDrv),
      .bDrv(bDrv), .parDrv(parDrv), .aClk(aClk), .bClk(bClk),
      .aEnN(aEnN), .bEnN(bEnN), .aOeN(aOeN), .bOeN(bOeN));

   // Compare and count
   task automatic check(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
      checksDone++;
      if (seen !== exp)
      begin
         badCount++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic conclude;
      $display("checks %0d mismatches %0d", checksDone, badCount);
      if (badCount == 0 && checksDone > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // One APB transfer; request held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         check("apb wait", 32'(pready), 32'h1);
         conclude();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic logic sig(input int k);
      case (k)
         0: return aFull;
         1: return bFull;
         2: return bPortOe;
         3: return aPortOe;
         default: return irq;
      endcase
   endfunction

   // Bounded wait on a design output; running out ends the run
   task automatic waitFor(input int k, input logic v);
      int n;
      n = 0;
      while (sig(k) !== v && n < 30)
      begin
         @(posedge core_clk);
         n++;
      end
      if (sig(k) !== v)
      begin
         check("wait", 32'(sig(k)), 32'(v));
         conclude();
      end
   endtask

   // Main sequence
   initial
   begin
      repeat (16) @(posedge core_clk);
      srst <= 1'b0;
      repeat (3) @(posedge core_clk);
      apb(0, rbp_pkg::PORT_STATE_OFS, 0);
      check("state", rd, 32'h00080000);
      check("fault", 32'(faultN), 32'h1);
      for (int s = 0; s < 2; s++)
      begin
         model_u.drive(s, 0);
         model_u.drive(s, 1);
      end
      repeat (6) @(posedge core_clk);
      check("flags", 32'({aFull, bFull}), 32'h0);
      $display("test reset done");
      for (int i = 0; i < 5; i++)
      begin
         model_u.send(0, vals[i], 0, 0, 0);
         waitFor(0, 1);
         check("b hold", 32'(bPortOut), 32'(vals[i]));
         check("b oe", 32'(bPortOe), 32'h0);
         model_u.drive(0, 0);
         waitFor(2, 1);
         repeat (2) @(posedge core_clk);
         check("b pins", 32'(bPortIn), 32'(vals[i]));
         check("parity", 32'(parityIn), 32'(~^vals[i]));
         check("parity oe", 32'(parityOe), 32'h1);
         model_u.drive(0, 1);
         waitFor(0, 0);
         check("b off", 32'({bPortOe, parityOe}), 32'h0);
      end
      $display("test a to b done");
      for (int i = 0; i < 5; i++)
      begin
         model_u.send(1, vals[i], i[0], 0, 0);
         waitFor(1, 1);
         apb(0, rbp_pkg::PORT_STATE_OFS, 0);
         check("s hold", 32'(rd[16:8]), 32'({i[0], vals[i]}));
         model_u.drive(1, 0);
         waitFor(3, 1);
         repeat (2) @(posedge core_clk);
         check("a pins", 32'(aPortIn), 32'(vals[i]));
         check("fault", 32'(faultN), 32'(^{i[0], vals[i]}));
         model_u.drive(1, 1);
         waitFor(1, 0);
         repeat (2) @(posedge core_clk);
         check("fault off", 32'(faultN), 32'h1);
         check("a oe", 32'(aPortOe), 32'h0);
      end
      $display("test b to a done");
      // Edge with enable high, then an edge while loads are held off
      model_u.send(0, 8'h5a, 0, 1, 0);
      check("hold flag", 32'(aFull), 32'h0);
      check("hold data", 32'(bPortOut), 32'(vals[4]));
      apb(1, rbp_pkg::CTRL_OFS, 1);
      model_u.send(0, 8'h5a, 0, 0, 0);
      check("held off", 32'(aFull), 32'h0);
      apb(1, rbp_pkg::CTRL_OFS, 0);
      // Acknowledge on the very edge of a load: the clear wins
      for (int s = 0; s < 2; s++)
      begin
         model_u.drive(s, 0);
         waitFor(2 + s, 1);
         model_u.send(s, 8'h3c, 1, 0, 1);
         check("ack wins", 32'(sig(s)), 32'h0);
      end
      $display("test hold and ack done");
      apb(1, rbp_pkg::IRQ_CLR_OFS, 32'h1f);
      apb(0, rbp_pkg::STATUS_OFS, 0);
      check("status clr", rd, 32'h0);
      model_u.send(0, 8'h81, 0, 0, 0);
      waitFor(0, 1);
      apb(0, rbp_pkg::STATUS_OFS, 0);
      check("status", rd, 32'h1);
      check("irq masked", 32'(irq), 32'h0);
      apb(1, rbp_pkg::IRQ_EN_OFS, 1);
      waitFor(4, 1);
      apb(1, rbp_pkg::IRQ_CLR_OFS, 1);
      waitFor(4, 0);
      apb(0, rbp_pkg::IRQ_EN_OFS, 0);
      check("irq en", rd, 32'h1);
      apb(0, 12'hffc, 0);
      check("slverr", 32'(err), 32'h1);
      $display("test irq and bus done");
      conclude();
   end
endmodule // registered_byte_port_parity_tb
